// ===== tb/nsh_src.sv
// converter core stand-in: sample source
`timescale 1ns/1ps
module nsh_src import nsh_pkg::*; (
	input  wire logic                         mclk,
	input  wire logic                         run,
	input  wire logic                         dc,
	input  wire logic signed [SMP_W-1:0]      level,
	output logic                              in_valid,
	output logic [NUM_CH-1:0][SMP_W-1:0]      in_data
);
	initial begin
		in_valid = 1'b0;
		in_data  = '0;
	end
	// data wanders every cycle, valid or not, unless dc holds every channel at level
	always @(posedge mclk) begin
		in_valid <= run && (dc || $urandom_range(3) != 0);
		for (int c = 0; c < NUM_CH; c++) begin
			in_data[c] <= dc ? level : SMP_W'($urandom);
		end
	end
endmodule

// ===== tb/nsh_top_asserts.sv
// port-level assertions for the output stage
`timescale 1ns/1ps
module nsh_top_asserts import nsh_pkg::*; #(
	parameter int NUM_CH = nsh_pkg::NUM_CH,
	parameter int SMP_W  = nsh_pkg::SMP_W,
	parameter int Q_BITS = nsh_pkg::Q_BITS
) (
	input wire logic                         mclk,
	input wire logic                         rst,
	input wire logic                         spi_sclk,
	input wire logic                         spi_cs_n,
	input wire logic                         spi_sdi,
	input wire logic                         spi_sdo,
	input wire logic                         spi_sdo_oe,
	input wire logic                         in_valid,
	input wire logic [NUM_CH-1:0][SMP_W-1:0] in_data,
	input wire logic [NUM_CH-1:0]            out_valid,
	input wire logic [NUM_CH-1:0][SMP_W-1:0] out_data
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------
	// config untouched since reset
	// ----------------------------------------------------------------
	logic untouched;
	logic next_untouched;
	always_comb begin
		next_untouched = untouched & spi_cs_n;
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			untouched <= 1'b1;
		end else begin
			untouched <= next_untouched;
		end
	end

	// ----------------------------------------------------------------
	// sequences and checks
	// ----------------------------------------------------------------
	sequence cs_idle_s;
		spi_cs_n [*8];
	endsequence
	sequence fresh_in_s;
		untouched && in_valid;
	endsequence

	idle_oe_low_a: assert property (cs_idle_s |-> !spi_sdo_oe)
		else $error("sdo driven while deselected");
	oe_needs_sel_a: assert property ($rose(spi_sdo_oe) |-> !spi_cs_n)
		else $error("sdo enabled without select");
	out_has_cause_a: assert property (|out_valid |->
		$past(in_valid) || $past(in_valid, 2) || $past(in_valid, 3) || $past(in_valid, 4))
		else $error("output sample without input");
	default_bypass_a: assert property (fresh_in_s |=> out_valid == '1)
		else $error("default path not one cycle");
	hold_data_a: assert property (untouched && !out_valid[0] |-> $stable(out_data[0]))
		else $error("output data moved without valid");
	coarse_chan_a_a: assert property (untouched && out_valid[0] |->
		out_data[0][SMP_W-Q_BITS-1:0] == '0)
		else $error("channel a not requantized");
	coarse_chan_b_a: assert property (untouched && out_valid[1] |->
		out_data[1][SMP_W-Q_BITS-1:0] == '0)
		else $error("channel b not requantized");
	twin_rate_a: assert property (untouched |-> out_valid[0] == out_valid[1])
		else $error("channels out of step");
endmodule

bind nsh_top nsh_top_asserts #(.NUM_CH(NUM_CH), .SMP_W(SMP_W), .Q_BITS(Q_BITS)) nsh_top_asserts_inst (
	.mclk(mclk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
	.spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .in_valid(in_valid), .in_data(in_data),
	.out_valid(out_valid), .out_data(out_data));

// ===== tb/test_nsh_top.sv
// self-checking bench for the output stage
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin errors++; \
	$display("unexpected %s exp %0h got %0h", nm, ex, gt); end end
module test_nsh_top import nsh_pkg::*; ();
	logic                         mclk     = 1'b0;
	logic                         rst      = 1'b1;
	logic                         spi_sclk = 1'b0;
	logic                         spi_cs_n = 1'b1;
	logic                         spi_sdi  = 1'b0;
	logic                         run      = 1'b0;
	logic                         dc       = 1'b0;
	logic signed [SMP_W-1:0]      level    = 14'sh1000;
	logic [NUM_CH-1:0]            raw      = '0;
	logic [NUM_CH-1:0]            qz       = '0;
	logic                         spi_sdo, spi_sdo_oe, in_valid;
	logic [NUM_CH-1:0][SMP_W-1:0] in_data, pd, out_data;
	logic [NUM_CH-1:0]            out_valid;
	int                           errors = 0, samples_checked = 0, n_in = 0, bad = 0;
	int                           n_out [NUM_CH];
	longint                       acc [NUM_CH];
	logic [14:0]                  ra [5] = '{REG_DEV_INDEX, REG_HB_CTRL, REG_RQ_MODE, REG_RQ_TUNE, 15'h0100};
	logic [7:0]                   rv [5] = '{8'h03, 8'h00, 8'h08, 8'h00, 8'h00};

	always #12.5 mclk = ~mclk;

	nsh_top nsh_top_inst (.mclk(mclk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .in_valid(in_valid),
		.in_data(in_data), .out_valid(out_valid), .out_data(out_data));
	nsh_src nsh_src_inst (.mclk(mclk), .run(run), .dc(dc), .level(level), .in_valid(in_valid),
		.in_data(in_data));

	// ----------------------------------------------------------------
	// output monitor
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		pd <= in_data;
		if (in_valid) n_in++;
		for (int c = 0; c < NUM_CH; c++) begin
			if (out_valid[c] === 1'b1) begin
				n_out[c]++;
				acc[c] += $signed(out_data[c]);
				if (raw[c] && out_data[c] !== pd[c]) bad++;
				if (qz[c] && out_data[c][4:0] !== 5'h00) bad++;
			end
		end
	end

	// ----------------------------------------------------------------
	// expectations
	// ----------------------------------------------------------------
	function automatic int atten(input int x);
		return $rtoi(x * (10.0 ** (-3.0 / 20.0)));
	endfunction
	function automatic real hb_gain(input int hp);
		int t[5] = '{25, -47, 93, -194, 644};
		int s = 0;
		foreach (t[i]) s += 2 * t[i];
		return (s + (hp ? -1024 : 1024)) / 2048.0;
	endfunction
	// shaping noise leaves a few coarse steps of spread
	function automatic logic near(input longint sum, input int n, input real ex);
		real avg;
		avg = (n > 0) ? real'(sum) / n : 1.0e9;
		return (avg - ex < 128.0) && (ex - avg < 128.0);
	endfunction

	// ----------------------------------------------------------------
	// drivers
	// ----------------------------------------------------------------
	task automatic spi(input logic is_rd, input logic [14:0] a, input logic [7:0] w, output logic [7:0] r);
		logic [23:0] f;
		f = {is_rd, a, w};
		r = 8'h00;
		spi_cs_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			spi_sdi <= f[i];
			repeat (5) @(posedge mclk);
			@(negedge mclk);
			if (i < 8) r = {r[6:0], spi_sdo};
			@(posedge mclk);
			spi_sclk <= 1'b1;
			repeat (6) @(posedge mclk);
			spi_sclk <= 1'b0;
		end
		repeat (8) @(posedge mclk);
		spi_cs_n <= 1'b1;
		repeat (8) @(posedge mclk);
	endtask
	task automatic wr_reg(input logic [14:0] a, input logic [7:0] w);
		logic [7:0] r;
		spi(1'b0, a, w, r);
	endtask
	task automatic rd_reg(input logic [14:0] a, output logic [7:0] r);
		spi(1'b1, a, 8'h00, r);
	endtask
	task automatic clr;
		@(negedge mclk);
		n_in = 0;
		bad = 0;
		n_out = '{default: 0};
		acc = '{default: 0};
		@(posedge mclk);
	endtask
	task automatic stream(input logic d, input int n);
		dc <= d;
		run <= 1'b1;
		repeat (n) @(posedge mclk);
		run <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask
	task automatic end_sim;
		if (errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge mclk);
		errors++;
		end_sim;
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] r, tune_w;
		void'($urandom(32'h6e5b));
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		// traffic before any frame: checker sees the untouched config
		qz <= 2'b11;
		clr;
		stream(1'b0, 200);
		`CHK("rate_a", n_in, n_out[0])
		`CHK("rate_b", n_in, n_out[1])
		`CHK("coarse", 0, bad)
		for (int i = 0; i < 5; i++) begin
			rd_reg(ra[i], r);
			`CHK("reg_reset", rv[i], r)
		end
		stream(1'b1, 40);
		clr;
		stream(1'b1, 200);
		`CHK("atten", 1'b1, near(acc[0], n_out[0], atten(4096)))
		wr_reg(REG_DEV_INDEX, 8'h02);
		wr_reg(REG_RQ_MODE, 8'h00);
		rd_reg(REG_RQ_MODE, r);
		`CHK("mode_b", 8'h00, r)
		wr_reg(REG_DEV_INDEX, 8'h01);
		rd_reg(REG_RQ_MODE, r);
		`CHK("mode_a", 8'h08, r)
		qz <= 2'b01;
		raw <= 2'b10;
		clr;
		stream(1'b0, 200);
		`CHK("split", 0, bad)
		wr_reg(REG_DEV_INDEX, 8'h03);
		wr_reg(REG_RQ_MODE, 8'h00);
		wr_reg(REG_HB_CTRL, 8'h01);
		rd_reg(REG_HB_CTRL, r);
		`CHK("hb_blocked", 8'h01, r)
		qz <= 2'b00;
		raw <= 2'b11;
		clr;
		stream(1'b0, 200);
		`CHK("blocked_raw", 0, bad)
		`CHK("blocked_rate", n_in, n_out[1])
		raw <= 2'b00;
		wr_reg(REG_RQ_MODE, 8'h08);
		rd_reg(REG_HB_CTRL, r);
		`CHK("hb_active", 8'h03, r)
		for (int hp = 0; hp < 2; hp++) begin
			wr_reg(REG_HB_CTRL, hp ? 8'h81 : 8'h01);
			stream(1'b1, 40);
			clr;
			stream(1'b1, 400);
			`CHK("decim", 1'b1, (n_in - 2 * n_out[0]) inside {[-2:2]})
			`CHK("hb_level", 1'b1, near(acc[0], n_out[0], atten(4096) * hb_gain(hp)))
		end
		wr_reg(REG_HB_CTRL, 8'h00);
		wr_reg(REG_RQ_MODE, 8'h09);
		rd_reg(REG_RQ_MODE, r);
		`CHK("mode28", 8'h09, r)
		repeat (3) begin
			tune_w = 8'($urandom_range(43));
			wr_reg(REG_RQ_TUNE, tune_w);
			rd_reg(REG_RQ_TUNE, r);
			`CHK("tune28", tune_w, r)
		end
		wr_reg(REG_RQ_MODE, 8'h08);
		wr_reg(REG_RQ_TUNE, 8'h3A);
		rd_reg(REG_RQ_TUNE, r);
		`CHK("tune21", 8'h3A, r)
		qz <= 2'b11;
		clr;
		stream(1'b0, 200);
		`CHK("tuned_rate", n_in, n_out[0])
		`CHK("tuned_coarse", 0, bad)
		end_sim;
	end
endmodule

// ===== verilog/nsh_pkg.sv
// shared constants, types and helpers for the output stage
package nsh_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int SMP_W  = 14;
	localparam int NUM_CH = 2;
	localparam int Q_BITS = 9;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int RW_BIT = 15;
	localparam int FRAME_BITS = 24;
	localparam int CNT_W  = 5;
	localparam logic [CNT_W-1:0] CNT_INSTR = 5'h10;
	localparam logic [CNT_W-1:0] CNT_FRAME = 5'h18;
	localparam logic [2:0] SYNC_RST = 3'h2;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_DEV_INDEX = 15'h0008;
	localparam logic [ADDR_W-1:0] REG_HB_CTRL   = 15'h041E;
	localparam logic [ADDR_W-1:0] REG_RQ_MODE   = 15'h0420;
	localparam logic [ADDR_W-1:0] REG_RQ_TUNE   = 15'h0422;
	localparam int HB_HP_BIT  = 7;
	localparam int HB_ACT_BIT = 1;
	localparam int HB_EN_BIT  = 0;
	localparam int RQ_EN_BIT  = 3;
	localparam int MODE_W     = 3;
	localparam int TUNE_W     = 6;
	localparam logic [7:0] DEV_INDEX_RST = 8'h03;
	localparam logic [7:0] HB_CTRL_RST   = 8'h00;
	localparam logic [7:0] RQ_MODE_RST   = 8'h08;
	localparam logic [7:0] RQ_TUNE_RST   = 8'h00;
	localparam logic [MODE_W-1:0] MODE_BW21 = 3'h0;
	localparam logic [MODE_W-1:0] MODE_BW28 = 3'h1;
	localparam logic [TUNE_W-1:0] TUNE_MAX_21 = 6'h3A;
	localparam logic [TUNE_W-1:0] TUNE_MAX_28 = 6'h2B;
	localparam logic [6:0] BW21_CENTRE = 7'h15;
	localparam logic [6:0] BW28_CENTRE = 7'h1C;

	typedef enum {RID_NONE, RID_INDEX, RID_HB, RID_MODE, RID_TUNE} nsh_reg_id_t;

	// ----------------------------------------------------------------
	// requantizer arithmetic
	// ----------------------------------------------------------------
	localparam logic signed [31:0] ATTEN_Q14 = 32'sh00002D4F;
	localparam int ATTEN_SHIFT = 14;
	localparam int COS_Q = 14;
	localparam logic [31:0] COS_ONE  = 32'h00004000;
	localparam logic [31:0] COS_STEP = 32'h00000203;
	localparam logic [31:0] INV24    = 32'h000002AB;
	localparam logic [31:0] INV30    = 32'h00000222;
	localparam logic [31:0] INV56    = 32'h00000125;
	localparam logic [6:0]  HALF_TURN    = 7'h64;
	localparam logic [6:0]  QUARTER_TURN = 7'h32;

	// ----------------------------------------------------------------
	// half-band filter
	// ----------------------------------------------------------------
	localparam int HB_TAPS   = 19;
	localparam int HB_CENTRE = 9;
	localparam int HB_PAIRS  = 5;
	localparam int HB_SHIFT  = 11;
	typedef logic signed [12:0] nsh_coef_t;
	localparam nsh_coef_t HB_COEF [HB_PAIRS] = '{13'sh0019, -13'sh002F, 13'sh005D, -13'sh00C2, 13'sh0284};
	localparam nsh_coef_t HB_CTR_COEF = 13'sh0400;

	localparam int SMP_MAX = (1 << (SMP_W - 1)) - 1;
	localparam int SMP_MIN = -(1 << (SMP_W - 1));

	// clip a wide value to the sample range
	function automatic logic signed [SMP_W-1:0] sat_smp(input logic signed [31:0] v);
		if (v > SMP_MAX) begin
			return SMP_W'(SMP_MAX);
		end else if (v < SMP_MIN) begin
			return SMP_W'(SMP_MIN);
		end
		return v[SMP_W-1:0];
	endfunction

endpackage

// ===== verilog/nsh_requantizer.sv
// noise-shaping requantizer for one channel
`timescale 1ns/1ps
module nsh_requantizer import nsh_pkg::*; #(
	parameter int SMP_W  = nsh_pkg::SMP_W,
	parameter int Q_BITS = nsh_pkg::Q_BITS
) (
	input  wire logic                    mclk,
	input  wire logic                    rst,
	input  wire logic                    in_valid,
	input  wire logic signed [SMP_W-1:0] in_data,
	input  wire logic                    rq_en,
	input  wire logic [MODE_W-1:0]       mode,
	input  wire logic [TUNE_W-1:0]       tune,
	nsh_stream_if.src                    out_s
);
	localparam int DROP     = SMP_W - Q_BITS;
	localparam int HALF_LSB = 1 << (DROP - 1);
	localparam int ERR_LIM  = 1 << DROP;

	logic signed [SMP_W-1:0] e1, e2, q_data;
	logic signed [SMP_W-1:0] next_e1, next_e2, next_data, y;
	logic                    q_valid, next_valid;
	logic        [TUNE_W-1:0] tune_lim, tune_c;
	logic        [6:0]       k;
	logic signed [31:0]      c2, xa, v, e;

	// cosine of k half-percent turns, Q14, by series
	function automatic logic signed [31:0] cos_q14(input logic [6:0] kin);
		logic [6:0]  kk;
		logic [31:0] x, x2, t2, t3, t4, c;
		kk = (kin > QUARTER_TURN) ? HALF_TURN - kin : kin;
		x  = 32'(kk) * COS_STEP;
		x2 = (x * x) >> COS_Q;
		t2 = (((x2 * x2) >> COS_Q) * INV24) >> COS_Q;
		t3 = (((t2 * x2) >> COS_Q) * INV30) >> COS_Q;
		t4 = (((t3 * x2) >> COS_Q) * INV56) >> COS_Q;
		c  = COS_ONE - (x2 >> 1) + t2 - t3 + t4;
		return (kin > QUARTER_TURN) ? -signed'(c) : signed'(c);
	endfunction

	always_comb begin
		// 21% profile and its centre offset
		// 28% profile and its centre offset
		tune_lim = (mode == MODE_BW28) ? TUNE_MAX_28 : TUNE_MAX_21;
		// words beyond range clamp to last
		tune_c = (tune > tune_lim) ? tune_lim : tune;
		k  = {1'b0, tune_c} + ((mode == MODE_BW28) ? BW28_CENTRE : BW21_CENTRE);
		c2 = cos_q14(k) <<< 1;
		xa = (32'(in_data) * ATTEN_Q14) >>> ATTEN_SHIFT;
		v  = xa - ((c2 * 32'(e1)) >>> COS_Q) + 32'(e2);
		y  = sat_smp(((v + HALF_LSB) >>> DROP) <<< DROP);
		y[DROP-1:0] = '0;
		e  = 32'(y) - v;
		if (e > ERR_LIM) begin
			e = ERR_LIM;
		end else if (e < -ERR_LIM) begin
			e = -ERR_LIM;
		end
		next_valid = in_valid;
		next_e1    = e1;
		next_e2    = e2;
		next_data  = q_data;
		if (in_valid) begin
			if (rq_en) begin
				next_data = y;
				next_e1   = e[SMP_W-1:0];
				next_e2   = e1;
			end else begin
				next_data = in_data;
				next_e1   = '0;
				next_e2   = '0;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			e1      <= '0;
			e2      <= '0;
			q_data  <= '0;
			q_valid <= 1'b0;
		end else begin
			e1      <= next_e1;
			e2      <= next_e2;
			q_data  <= next_data;
			q_valid <= next_valid;
		end
	end

	assign out_s.valid = q_valid;
	assign out_s.data  = q_data;
endmodule

// ===== verilog/nsh_stream_if.sv
// sample stream between requantizer and output stage
`timescale 1ns/1ps
interface nsh_stream_if #(parameter int W = 14) ();
	logic                valid;
	logic signed [W-1:0] data;
	modport src (output valid, output data);
	modport snk (input valid, input data);
endinterface

// ===== verilog/nsh_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module nsh_sync #(
	parameter int         W       = 3,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1, s2, s3;
	logic [W-1:0] next_q;

	// a bit changes once stages two and three agree
	always_comb begin
		for (int i = 0; i < W; i++) begin
			next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			q  <= RST_VAL;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q  <= next_q;
		end
	end
endmodule

// ===== verilog/nsh_top.sv
// dual-channel requantizer and half-band decimator with spi registers
`timescale 1ns/1ps
module nsh_top import nsh_pkg::*; #(
	parameter int NUM_CH = nsh_pkg::NUM_CH,
	parameter int SMP_W  = nsh_pkg::SMP_W,
	parameter int Q_BITS = nsh_pkg::Q_BITS
) (
	input  wire logic                          mclk,
	input  wire logic                          rst,
	input  wire logic                          spi_sclk,
	input  wire logic                          spi_cs_n,
	input  wire logic                          spi_sdi,
	output logic                               spi_sdo,
	output logic                               spi_sdo_oe,
	input  wire logic                          in_valid,
	input  wire logic [NUM_CH-1:0][SMP_W-1:0]  in_data,
	output logic      [NUM_CH-1:0]             out_valid,
	output logic      [NUM_CH-1:0][SMP_W-1:0]  out_data
);
	localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

	// ----------------------------------------------------------------
	// spi pin synchronisers
	// ----------------------------------------------------------------
	logic       sclk_f, cs_n_f, sdi_f;
	logic [2:0] pins_q;

	nsh_sync #(
		.W       (3),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    ({spi_sclk, spi_cs_n, spi_sdi}),
		.q    (pins_q)
	);

	assign sclk_f = pins_q[2];
	assign cs_n_f = pins_q[1];
	assign sdi_f  = pins_q[0];

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [NUM_CH-1:0] dev_index, next_dev_index;
	logic [NUM_CH-1:0] hb_en, next_hb_en;
	logic [NUM_CH-1:0] hb_hp, next_hb_hp;
	logic [NUM_CH-1:0] rq_en, next_rq_en;
	logic [NUM_CH-1:0] hb_act;
	logic [MODE_W-1:0] rq_mode [NUM_CH];
	logic [MODE_W-1:0] next_rq_mode [NUM_CH];
	logic [TUNE_W-1:0] tune [NUM_CH];
	logic [TUNE_W-1:0] next_tune [NUM_CH];

	// ----------------------------------------------------------------
	// spi frame state
	// ----------------------------------------------------------------
	logic                  sclk_q, sclk_rise, sclk_fall;
	logic [CNT_W-1:0]      cnt, next_cnt;
	logic [FRAME_BITS-1:0] shift, next_shift;
	logic [ADDR_W-1:0]     spi_addr, next_addr;
	logic                  spi_rd, next_rd;
	logic [DATA_W-1:0]     sdo_sh, next_sdo_sh;
	logic [15:0]           instr;
	logic                  wr_en;
	logic [DATA_W-1:0]     wr_data;
	logic [DATA_W-1:0]     rd_data;
	logic [CH_W-1:0]       rd_ch;

	// which register an address names
	function automatic nsh_reg_id_t reg_decode(input logic [ADDR_W-1:0] a);
		case (a)
			REG_DEV_INDEX: reg_decode = RID_INDEX;
			REG_HB_CTRL:   reg_decode = RID_HB;
			REG_RQ_MODE:   reg_decode = RID_MODE;
			REG_RQ_TUNE:   reg_decode = RID_TUNE;
			default:       reg_decode = RID_NONE;
		endcase
	endfunction

	assign sclk_rise = sclk_f & ~sclk_q;
	assign sclk_fall = ~sclk_f & sclk_q;
	assign instr     = {shift[14:0], sdi_f};

	// ----------------------------------------------------------------
	// read data mux
	// ----------------------------------------------------------------
	// reads answer from the lowest selected channel
	always_comb begin
		rd_ch = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (dev_index[i]) begin
				rd_ch = CH_W'(i);
			end
		end
	end

	always_comb begin
		rd_data = '0;
		case (reg_decode(instr[ADDR_W-1:0]))
			RID_INDEX: begin
				rd_data[NUM_CH-1:0] = dev_index;
			end
			RID_HB: begin
				rd_data[HB_HP_BIT]  = hb_hp[rd_ch];
				rd_data[HB_ACT_BIT] = hb_act[rd_ch];
				rd_data[HB_EN_BIT]  = hb_en[rd_ch];
			end
			RID_MODE: begin
				rd_data[RQ_EN_BIT]    = rq_en[rd_ch];
				rd_data[MODE_W-1:0]   = rq_mode[rd_ch];
			end
			RID_TUNE: begin
				rd_data[TUNE_W-1:0] = tune[rd_ch];
			end
			default: begin
				rd_data = '0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// spi framing: 16-bit instruction, one data byte
	// ----------------------------------------------------------------
	always_comb begin
		next_cnt    = cnt;
		next_shift  = shift;
		next_addr   = spi_addr;
		next_rd     = spi_rd;
		next_sdo_sh = sdo_sh;
		wr_en       = 1'b0;
		wr_data     = '0;
		if (cs_n_f) begin
			next_cnt = '0;
			next_rd  = 1'b0;
		end else if (sclk_rise && cnt < CNT_FRAME) begin
			next_shift = {shift[FRAME_BITS-2:0], sdi_f};
			next_cnt   = cnt + 5'h01;
			if (cnt == CNT_INSTR - 5'h01) begin
				next_addr   = instr[ADDR_W-1:0];
				next_rd     = instr[RW_BIT];
				next_sdo_sh = rd_data;
			end
			if (cnt == CNT_FRAME - 5'h01 && !spi_rd) begin
				wr_en   = 1'b1;
				wr_data = {shift[DATA_W-2:0], sdi_f};
			end
		end else if (sclk_fall && cnt > CNT_INSTR && cnt < CNT_FRAME) begin
			next_sdo_sh = {sdo_sh[DATA_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sclk_q   <= 1'b0;
			cnt      <= '0;
			shift    <= '0;
			spi_addr <= '0;
			spi_rd   <= 1'b0;
			sdo_sh   <= '0;
		end else begin
			sclk_q   <= sclk_f;
			cnt      <= next_cnt;
			shift    <= next_shift;
			spi_addr <= next_addr;
			spi_rd   <= next_rd;
			sdo_sh   <= next_sdo_sh;
		end
	end

	assign spi_sdo    = sdo_sh[DATA_W-1];
	assign spi_sdo_oe = ~cs_n_f & spi_rd & (cnt >= CNT_INSTR);

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_comb begin
		next_dev_index = dev_index;
		next_hb_en     = hb_en;
		next_hb_hp     = hb_hp;
		next_rq_en     = rq_en;
		next_rq_mode   = rq_mode;
		next_tune      = tune;
		if (wr_en && reg_decode(spi_addr) == RID_INDEX) begin
			next_dev_index = wr_data[NUM_CH-1:0];
		end
		// each selected channel takes its own copy
		for (int ch = 0; ch < NUM_CH; ch++) begin
			if (wr_en && dev_index[ch]) begin
				case (reg_decode(spi_addr))
					RID_HB: begin
						next_hb_hp[ch] = wr_data[HB_HP_BIT];
						next_hb_en[ch] = wr_data[HB_EN_BIT];
					end
					RID_MODE: begin
						next_rq_en[ch]   = wr_data[RQ_EN_BIT];
						next_rq_mode[ch] = wr_data[MODE_W-1:0];
					end
					RID_TUNE: begin
						next_tune[ch] = wr_data[TUNE_W-1:0];
					end
					default: begin
						next_tune[ch] = tune[ch];
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dev_index <= DEV_INDEX_RST[NUM_CH-1:0];
			hb_en     <= {NUM_CH{HB_CTRL_RST[HB_EN_BIT]}};
			hb_hp     <= {NUM_CH{HB_CTRL_RST[HB_HP_BIT]}};
			rq_en     <= {NUM_CH{RQ_MODE_RST[RQ_EN_BIT]}};
			for (int ch = 0; ch < NUM_CH; ch++) begin
				rq_mode[ch] <= RQ_MODE_RST[MODE_W-1:0];
				tune[ch]    <= RQ_TUNE_RST[TUNE_W-1:0];
			end
		end else begin
			dev_index <= next_dev_index;
			hb_en     <= next_hb_en;
			hb_hp     <= next_hb_hp;
			rq_en     <= next_rq_en;
			rq_mode   <= next_rq_mode;
			tune      <= next_tune;
		end
	end

	// filter runs only with requantizer on
	assign hb_act = hb_en & rq_en;

	// ----------------------------------------------------------------
	// per-channel datapath
	// ----------------------------------------------------------------
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
		nsh_stream_if #(.W(SMP_W)) rq_s ();

		logic signed [SMP_W-1:0] dl [HB_TAPS];
		logic signed [SMP_W-1:0] next_dl [HB_TAPS];
		logic signed [SMP_W-1:0] hb_data, next_hb_data;
		logic                    hb_valid, next_hb_valid;
		logic                    phase, next_phase;
		logic                    calc, next_calc;
		logic signed [31:0]      acc;

		nsh_requantizer #(
			.SMP_W  (SMP_W),
			.Q_BITS (Q_BITS)
		) u_rq (
			.mclk     (mclk),
			.rst      (rst),
			.in_valid (in_valid),
			.in_data  (in_data[ch]),
			.rq_en    (rq_en[ch]),
			.mode     (rq_mode[ch]),
			.tune     (tune[ch]),
			.out_s    (rq_s.src)
		);

		always_comb begin
			next_dl       = dl;
			next_phase    = phase;
			next_calc     = 1'b0;
			next_hb_data  = hb_data;
			next_hb_valid = 1'b0;
			acc           = '0;
			// symmetric pairs pre-added, only even taps
			// taps give the stated alias rejection
			for (int i = 0; i < HB_PAIRS; i++) begin
				acc = acc + 32'(HB_COEF[i]) * (32'(dl[2*i]) + 32'(dl[HB_TAPS-1-2*i]));
			end
			// sign choice sets the kept zones
			if (hb_hp[ch]) begin
				acc = acc - 32'(HB_CTR_COEF) * 32'(dl[HB_CENTRE]);
			end else begin
				acc = acc + 32'(HB_CTR_COEF) * 32'(dl[HB_CENTRE]);
			end
			if (!hb_act[ch]) begin
				next_phase = 1'b0;
			end else if (rq_s.valid) begin
				next_dl[0] = rq_s.data;
				for (int i = 1; i < HB_TAPS; i++) begin
					next_dl[i] = dl[i-1];
				end
				next_phase = ~phase;
				next_calc  = phase;
			end
			if (calc) begin
				next_hb_data  = sat_smp(acc >>> HB_SHIFT);
				next_hb_valid = 1'b1;
			end
		end

		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				for (int i = 0; i < HB_TAPS; i++) begin
					dl[i] <= '0;
				end
				hb_data  <= '0;
				hb_valid <= 1'b0;
				phase    <= 1'b0;
				calc     <= 1'b0;
			end else begin
				dl       <= next_dl;
				hb_data  <= next_hb_data;
				hb_valid <= next_hb_valid;
				phase    <= next_phase;
				calc     <= next_calc;
			end
		end

		assign out_valid[ch] = hb_act[ch] ? hb_valid : rq_s.valid;
		assign out_data[ch]  = hb_act[ch] ? hb_data : rq_s.data;
	end
endmodule
